// ===== swc_cfg.svh
// Constants for the sleep and wake-up controller: offsets, fields, resets, timing.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// Register byte offsets.
`define SWC_CTRL_OFS 8'h00
`define SWC_STAT_OFS 8'h04
`define SWC_EVST_OFS 8'h08
`define SWC_EVMK_OFS 8'h0C

// Control register fields.
`define SWC_C_GIE 0
`define SWC_C_EDGE 1
`define SWC_C_EXTEN 2
`define SWC_C_WDTEN 3
`define SWC_C_RCOSC 4
`define SWC_C_T1ASYNC 5
`define SWC_C_ADRC 6
`define SWC_C_PORTEN 7
`define SWC_C_PEN_LSB 8
`define SWC_CTRL_RST 16'h0000

// Status register fields.
`define SWC_S_PD 0
`define SWC_S_TO 1
`define SWC_S_ASLEEP 2
`define SWC_S_EXTF 3

// Event bits of the interrupt status and mask registers.
`define SWC_E_SLEEP 0
`define SWC_E_IRQWAKE 1
`define SWC_E_WDTWAKE 2
`define SWC_E_NOP 3
`define SWC_EVMK_RST 4'h0

// Peripheral wake source positions.
`define SWC_P_TIMER_ONE 1
`define SWC_P_SPEC 3
`define SWC_P_ADC 6

// Oscillator start-up delay; the device clock is the main oscillator.
`define SWC_OST_PERIODS 1024
`define SWC_OSC_PER_CYCLE 1
`define SWC_OST_CYCLES (`SWC_OST_PERIODS * `SWC_OSC_PER_CYCLE)

// AXI responses.
`define SWC_RESP_OKAY 2'h0
`define SWC_RESP_SLVERR 2'h2

`endif

// ===== swc_core_model.sv
// Behavioural model of the core and watchdog facing the sleep controller.
// Assumes one clock; the watchdog's own oscillator is modelled on mclk.
`timescale 1ns/1ps

module swc_core_model #(
   parameter int WDT_LIMIT = 200
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Bench controls
   input wire logic stepReq,
   input wire logic wdtRun,
   // Controller side
   input wire logic coreStall,
   input wire logic wdtClear,
   output logic instrDone,
   output logic wdtTimeout
);
   int wdtCount;
   logic wrap;

   assign wrap = wdtCount == WDT_LIMIT - 1;

   // The watchdog keeps counting through sleep; a clear, a wrap or dropping wdtRun restarts it.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         instrDone <= 1'b0;
         wdtTimeout <= 1'b0;
         wdtCount <= 0;
      end
      else
      begin
         instrDone <= stepReq && !coreStall;
         wdtTimeout <= wdtRun && !wdtClear && wrap;
         wdtCount <= (!wdtRun || wdtClear || wrap) ? 0 : wdtCount + 1;
      end
   end
endmodule

// ===== swc_pkg.sv
// Types shared by the sleep and wake-up controller.
// Assumes swc_cfg.svh carries the register, bus and start-up constants.
package swc_pkg;
   typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_START, SWC_RESUME} swc_state_t;
endpackage

// ===== swc_sleep_ctrl.sv
// Sleep entry, wake-up sequencing and status flags of a small microcontroller core.
// Assumes the core, watchdog and peripherals drive pulses synchronous to mclk.
//
// What this block does
// - Sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - Port pins keep their pre-sleep drive state while asleep.
// - Wake on master clear, enabled watchdog timeout, or enabled interrupt.
// - Master clear resets the device; other wake sources resume execution.
// - Watchdog wake-up clears the timeout flag.
// - Power-down flag set at power-up, cleared by each completed sleep.
// - Only clockless peripheral interrupts may wake the device.
// - Timer-one wakes only when asynchronous; converter only on RC clock.
// - Sleep prefetches the instruction at program counter plus one.
// - Wake needs the source enable, regardless of global enable.
// - After interrupt wake run next instruction, then vector if global enable.
// - Pending enabled interrupt before sleep makes sleep a no-operation.
// - Interrupt during or after sleep: complete sleep fully, then wake.
// - Crystal modes wait 1024 oscillator periods on wake; RC mode does not.
// - Watchdog timeout resets when running, wakes when asleep.
// - Taking an interrupt clears global enable, loads vector.
`timescale 1ns/1ps
`include "swc_cfg.svh"

module swc_sleep_ctrl #(
   parameter int PCW = 13,
   parameter int PW = 8,
   parameter logic [PCW-1:0] VECTOR_ADDR = 13'h0004
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // AXI4-Lite register slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Core pipeline
   input wire logic sleepExec,
   input wire logic instrDone,
   input wire logic retfie,
   input wire logic [PCW-1:0] pc,
   output logic prefetchStb,
   output logic [PCW-1:0] prefetchAddr,
   output logic vectorStb,
   output logic [PCW-1:0] vectorAddr,
   output logic coreStall,
   // Reset, watchdog and oscillator
   input wire logic masterClearPinN,
   input wire logic wdtTimeout,
   output logic wdtClear,
   output logic deviceReset,
   output logic oscEnable,
   // Interrupt sources
   input wire logic extIrqPin,
   input wire logic portChangeFlag,
   input wire logic [7:0] periphFlag,
   // Port drive hold
   input wire logic [PW-1:0] portDrive,
   input wire logic [PW-1:0] portDriveOe,
   output logic [PW-1:0] portHeld,
   output logic [PW-1:0] portHeldOe,
   // Interrupt to host
   output logic irq
);
   import swc_pkg::*;

   typedef struct packed {
      swc_state_t state;
      logic [15:0] ctrl;
      logic pd;
      logic to;
      logic extFlag;
      logic extPinQ;
      logic [3:0] evStatus;
      logic [3:0] evMask;
      logic irq;
      logic osc;
      logic wdtClr;
      logic preStb;
      logic [PCW-1:0] preAddr;
      logic vecStb;
      logic devRst;
      logic ioHold;
      logic stall;
      logic [PW-1:0] portOut;
      logic [PW-1:0] portOe;
      logic [10:0] ost;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } swc_regs_t;

   localparam logic [10:0] OST_LAST = 11'(`SWC_OST_CYCLES - 1);

   swc_regs_t s;
   swc_regs_t next_s;

   // ----------------------------------------------------------------
   // Wake and interrupt request
   // ----------------------------------------------------------------
   logic [7:0] periphAllow;
   logic irqAny;
   logic wakeAny;
   logic extEdge;
   logic wdtFire;

   always_comb
   begin
      periphAllow = 8'hFF;
      periphAllow[`SWC_P_TIMER_ONE] = s.ctrl[`SWC_C_T1ASYNC];
      periphAllow[`SWC_P_SPEC] = s.ctrl[`SWC_C_T1ASYNC];
      periphAllow[`SWC_P_ADC] = s.ctrl[`SWC_C_ADRC];
   end

   // Plain AND-OR of flags and enables, so no clocked stage sits in the wake path.
   assign irqAny = (s.extFlag & s.ctrl[`SWC_C_EXTEN])
      | (portChangeFlag & s.ctrl[`SWC_C_PORTEN])
      | (|(periphFlag & s.ctrl[15:8]));
   assign wakeAny = (s.extFlag & s.ctrl[`SWC_C_EXTEN])
      | (portChangeFlag & s.ctrl[`SWC_C_PORTEN])
      | (|(periphFlag & s.ctrl[15:8] & periphAllow));
   assign extEdge = s.ctrl[`SWC_C_EDGE] ? (extIrqPin & ~s.extPinQ)
      : (~extIrqPin & s.extPinQ);
   assign wdtFire = wdtTimeout & s.ctrl[`SWC_C_WDTEN];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [3:0] ev;
      logic [31:0] rd;
      logic [1:0] rr;
      logic wrDo;
      ev = 4'h0;
      rd = 32'h0000_0000;
      rr = `SWC_RESP_OKAY;
      wrDo = s.awHeld & s.wHeld & ~s.bvalid;
      next_s = s;
      next_s.wdtClr = 1'b0;
      next_s.preStb = 1'b0;
      next_s.vecStb = 1'b0;
      next_s.devRst = 1'b0;
      next_s.extPinQ = extIrqPin;

      // Write channel: address and data are taken in either order.
      if (awvalid && s.awready)
      begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = awaddr;
         next_s.awready = 1'b0;
      end
      if (wvalid && s.wready)
      begin
         next_s.wHeld = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
         next_s.wready = 1'b0;
      end
      if (wrDo)
      begin
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `SWC_RESP_OKAY;
         unique case (s.awAddr)
            `SWC_CTRL_OFS:
            begin
               if (s.wStrb[0])
                  next_s.ctrl[7:0] = s.wData[7:0];
               if (s.wStrb[1])
                  next_s.ctrl[15:8] = s.wData[15:8];
            end
            `SWC_STAT_OFS:
            begin
               if (s.wStrb[0] && s.wData[`SWC_S_EXTF])
                  next_s.extFlag = 1'b0;
            end
            `SWC_EVST_OFS:
            begin
               if (s.wStrb[0])
                  next_s.evStatus = s.evStatus & ~s.wData[3:0];
            end
            `SWC_EVMK_OFS:
            begin
               if (s.wStrb[0])
                  next_s.evMask = s.wData[3:0];
            end
            default:
               next_s.bresp = `SWC_RESP_SLVERR;
         endcase
      end
      if (s.bvalid && bready)
      begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      // Read channel.
      unique case (araddr)
         `SWC_CTRL_OFS:
            rd[15:0] = s.ctrl;
         `SWC_STAT_OFS:
         begin
            rd[`SWC_S_PD] = s.pd;
            rd[`SWC_S_TO] = s.to;
            rd[`SWC_S_ASLEEP] = (s.state == SWC_SLEEP);
            rd[`SWC_S_EXTF] = s.extFlag;
         end
         `SWC_EVST_OFS:
            rd[3:0] = s.evStatus;
         `SWC_EVMK_OFS:
            rd[3:0] = s.evMask;
         default:
            rr = `SWC_RESP_SLVERR;
      endcase
      if (arvalid && s.arready)
      begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rdata = rd;
         next_s.rresp = rr;
      end
      if (s.rvalid && rready)
      begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end

      if (retfie)
         next_s.ctrl[`SWC_C_GIE] = 1'b1;

      // Sequencer.
      if (!masterClearPinN)
      begin
         next_s.devRst = 1'b1;
         next_s.state = SWC_RUN;
         next_s.osc = 1'b1;
         next_s.ioHold = 1'b0;
         next_s.ctrl[`SWC_C_GIE] = 1'b0;
      end
      else
      begin
         unique case (s.state)
            SWC_RUN:
            begin
               if (sleepExec)
               begin
                  next_s.preStb = 1'b1;
                  next_s.preAddr = PCW'(pc + 1'b1);
                  // An enabled flag already pending turns the sleep into a no-operation.
                  if (irqAny)
                     ev[`SWC_E_NOP] = 1'b1;
                  else
                  begin
                     next_s.wdtClr = 1'b1;
                     next_s.pd = 1'b0;
                     next_s.to = 1'b1;
                     next_s.osc = 1'b0;
                     next_s.ioHold = 1'b1;
                     next_s.state = SWC_SLEEP;
                     ev[`SWC_E_SLEEP] = 1'b1;
                  end
               end
               else if (wdtFire)
               begin
                  next_s.devRst = 1'b1;
                  next_s.to = 1'b0;
               end
               else if (instrDone && s.ctrl[`SWC_C_GIE] && irqAny)
               begin
                  next_s.vecStb = 1'b1;
                  next_s.ctrl[`SWC_C_GIE] = 1'b0;
               end
            end
            SWC_SLEEP:
            begin
               if (wdtFire || wakeAny)
               begin
                  next_s.osc = 1'b1;
                  next_s.ost = 11'h000;
                  if (wdtFire)
                  begin
                     next_s.to = 1'b0;
                     ev[`SWC_E_WDTWAKE] = 1'b1;
                  end
                  else
                     ev[`SWC_E_IRQWAKE] = 1'b1;
                  if (s.ctrl[`SWC_C_RCOSC])
                  begin
                     next_s.state = SWC_RESUME;
                     next_s.ioHold = 1'b0;
                  end
                  else
                     next_s.state = SWC_START;
               end
            end
            SWC_START:
            begin
               next_s.ost = s.ost + 11'h001;
               if (s.ost == OST_LAST)
               begin
                  next_s.state = SWC_RESUME;
                  next_s.ioHold = 1'b0;
               end
            end
            SWC_RESUME:
            begin
               // The instruction after sleep runs first, then the vector is taken.
               if (instrDone)
               begin
                  next_s.state = SWC_RUN;
                  if (s.ctrl[`SWC_C_GIE] && irqAny)
                  begin
                     next_s.vecStb = 1'b1;
                     next_s.ctrl[`SWC_C_GIE] = 1'b0;
                  end
               end
            end
         endcase
      end

      // Hardware sets win over software clears in the same cycle.
      if (extEdge)
         next_s.extFlag = 1'b1;
      next_s.evStatus = next_s.evStatus | ev;
      next_s.irq = |(next_s.evStatus & next_s.evMask);
      next_s.stall = (next_s.state == SWC_SLEEP) || (next_s.state == SWC_START);
      // Held drive values follow the core until sleep freezes them.
      if (!next_s.ioHold)
      begin
         next_s.portOut = portDrive;
         next_s.portOe = portDriveOe;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= '0;
         s.state <= SWC_RUN;
         s.ctrl <= `SWC_CTRL_RST;
         s.evMask <= `SWC_EVMK_RST;
         s.pd <= 1'b1;
         s.to <= 1'b1;
         s.osc <= 1'b1;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign prefetchStb = s.preStb;
   assign prefetchAddr = s.preAddr;
   assign vectorStb = s.vecStb;
   assign vectorAddr = VECTOR_ADDR;
   assign coreStall = s.stall;
   assign wdtClear = s.wdtClr;
   assign deviceReset = s.devRst;
   assign oscEnable = s.osc;
   assign portHeld = s.portOut;
   assign portHeldOe = s.portOe;
   assign irq = s.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   AST_SLEEP_ENTRY: assert property (
      s.state == SWC_RUN && sleepExec && !irqAny && masterClearPinN
      |=> wdtClear && !s.pd && s.to && !oscEnable && s.state == SWC_SLEEP)
      else $error("sleep entry did not update flags");
   AST_NOP_SLEEP: assert property (
      s.state == SWC_RUN && sleepExec && irqAny && masterClearPinN
      |=> !wdtClear && $stable(s.pd) && s.state == SWC_RUN)
      else $error("pending interrupt did not make sleep a no-op");
   AST_PORT_HOLD: assert property (
      s.state == SWC_SLEEP && $past(s.state) == SWC_SLEEP |-> $stable(portHeld)
      && $stable(portHeldOe))
      else $error("port drive changed while asleep");
   AST_PREFETCH: assert property (
      s.state == SWC_RUN && sleepExec && masterClearPinN
      |=> prefetchStb && prefetchAddr == PCW'($past(pc) + 1'b1))
      else $error("prefetch address wrong");
   AST_WDT_WAKE: assert property (
      s.state == SWC_SLEEP && wdtFire && masterClearPinN
      |=> !s.to && !deviceReset && s.state != SWC_SLEEP)
      else $error("watchdog wake-up wrong");
   AST_WDT_RESET: assert property (
      s.state == SWC_RUN && wdtFire && !sleepExec && masterClearPinN
      |=> deviceReset && !s.to)
      else $error("watchdog did not reset while running");
   AST_MASTER_CLEAR_PIN: assert property (
      !masterClearPinN |=> deviceReset && s.state == SWC_RUN && oscEnable)
      else $error("master clear did not reset");
   AST_OST_LEN: assert property (
      s.state == SWC_RESUME && $past(s.state) == SWC_START
      |-> $past(s.ost) == OST_LAST)
      else $error("start-up delay length wrong");
   AST_RC_NODELAY: assert property (
      s.state == SWC_SLEEP && wakeAny && !wdtFire && masterClearPinN
      && s.ctrl[`SWC_C_RCOSC] |=> s.state == SWC_RESUME)
      else $error("RC mode waited for start-up");
   AST_WAKE_NO_GIE: assert property (
      s.state == SWC_SLEEP && wakeAny && !s.ctrl[`SWC_C_GIE] && masterClearPinN
      |=> s.state != SWC_SLEEP ##0 oscEnable)
      else $error("enabled interrupt did not wake");
   AST_VECTOR: assert property (
      s.state == SWC_RESUME && instrDone && s.ctrl[`SWC_C_GIE] && irqAny
      && masterClearPinN && !retfie |=> vectorStb && !s.ctrl[`SWC_C_GIE])
      else $error("vector not taken after wake");
   AST_EXT_EDGE: assert property (
      extEdge |=> s.extFlag)
      else $error("external edge not flagged");
endmodule

// ===== tb_sleep_wakeup_control.sv
// Self-checking bench for the sleep and wake-up controller.
// Assumes swc_cfg.svh and the core model; registers over AXI4-Lite.
`timescale 1ns/1ps
`include "swc_cfg.svh"

module tb_sleep_wakeup_control;
   localparam logic [31:0] GLOBAL_IRQ_ENABLE = 32'h0000_0001 << `SWC_C_GIE;
   localparam logic [31:0] EDG = 32'h0000_0001 << `SWC_C_EDGE;
   localparam logic [31:0] EXT = 32'h0000_0001 << `SWC_C_EXTEN;
   localparam logic [31:0] WDT = 32'h0000_0001 << `SWC_C_WDTEN;
   localparam logic [31:0] RC = 32'h0000_0001 << `SWC_C_RCOSC;
   localparam logic [31:0] T1A = 32'h0000_0001 << `SWC_C_T1ASYNC;
   localparam logic [31:0] ADRC = 32'h0000_0001 << `SWC_C_ADRC;
   localparam logic [31:0] PRT = 32'h0000_0001 << `SWC_C_PORTEN;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic sleepExec = 1'b0, retfie = 1'b0, masterClearPinN = 1'b1, extIrqPin = 1'b0;
   logic portChangeFlag = 1'b0, stepReq = 1'b0, wdtRun = 1'b0;
   logic [12:0] pc = 13'h0000;
   logic [7:0] periphFlag = 8'h00, portDrive = 8'h00, portDriveOe = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, prefetchStb, vectorStb, coreStall;
   logic wdtClear, deviceReset, oscEnable, irq, instrDone, wdtTimeout;
   logic [1:0] bresp, rresp, lastResp;
   logic [31:0] rdata, lastData;
   logic [12:0] prefetchAddr, vectorAddr, pcVal;
   logic [7:0] portHeld, portHeldOe;
   int n_errors = 0;
   int tests_run = 0;

   always #4 mclk = ~mclk;

   swc_sleep_ctrl swc_sleep_ctrl_inst (
      .mclk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .sleepExec, .instrDone, .retfie, .pc, .prefetchStb, .prefetchAddr,
      .vectorStb, .vectorAddr, .coreStall, .masterClearPinN, .wdtTimeout, .wdtClear,
      .deviceReset, .oscEnable, .extIrqPin, .portChangeFlag, .periphFlag, .portDrive,
      .portDriveOe, .portHeld, .portHeldOe, .irq
   );

   swc_core_model swc_core_model_inst (
      .mclk, .resetn, .stepReq, .wdtRun, .coreStall, .wdtClear, .instrDone, .wdtTimeout
   );

   // ----------------------------------------
   // Expectations and checking
   // ----------------------------------------
   function automatic logic [31:0] stat(input logic pdV, input logic toV, input logic slp);
      stat = 32'h0000_0000;
      stat[`SWC_S_PD] = pdV;
      stat[`SWC_S_TO] = toV;
      stat[`SWC_S_ASLEEP] = slp;
   endfunction

   function automatic logic [31:0] pen(input int b);
      return 32'h0000_0001 << (`SWC_C_PEN_LSB + b);
   endfunction

   task automatic end_sim();
      $display("Checks: %0d, mismatches: %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t ns %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic fail_to(input string what);
      n_errors++;
      $display("[FAIL] %0t ns no answer: %s", $time, what);
      end_sim();
   endtask

   // ----------------------------------------
   // Bus and core drivers
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aT, wT, bT;
      int n;
      bT = 1'b0;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bT)
      begin
         #1;
         aT = awvalid && awready;
         wT = wvalid && wready;
         bT = bvalid;
         lastResp = bresp;
         @(posedge mclk);
         if (aT)
            awvalid <= 1'b0;
         if (wT)
            wvalid <= 1'b0;
         if (++n > 50)
            fail_to("write");
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic aT, rT;
      int n;
      rT = 1'b0;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rT)
      begin
         #1;
         aT = arvalid && arready;
         rT = rvalid;
         lastData = rdata;
         lastResp = rresp;
         @(posedge mclk);
         if (aT)
            arvalid <= 1'b0;
         if (++n > 50)
            fail_to("read");
      end
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(lastData, exp, what);
   endtask

   task automatic do_sleep();
      @(posedge mclk);
      pcVal = 13'($urandom);
      pc <= pcVal;
      sleepExec <= 1'b1;
      @(posedge mclk);
      sleepExec <= 1'b0;
      #1;
   endtask

   task automatic wait_osc(input int lim);
      int n;
      n = 0;
      while (oscEnable !== 1'b1)
      begin
         @(posedge mclk);
         #1;
         if (++n > lim)
            fail_to("wake");
      end
   endtask

   // Watches three cycles after one completed instruction for a vector branch.
   task automatic step(output logic seen);
      seen = 1'b0;
      @(posedge mclk);
      stepReq <= 1'b1;
      @(posedge mclk);
      stepReq <= 1'b0;
      repeat (3)
      begin
         @(posedge mclk);
         #1;
         seen = seen | vectorStb;
      end
   endtask

   task automatic sleep_wake(input logic [31:0] cw, input logic [7:0] pf, input logic pcf,
      input logic ext);
      logic sn;
      @(posedge mclk);
      extIrqPin <= !ext;
      wr(`SWC_CTRL_OFS, cw);
      wr(`SWC_STAT_OFS, 32'h0000_0008);
      do_sleep();
      chk(oscEnable, 1'b0, "asleep");
      @(posedge mclk);
      periphFlag <= pf;
      portChangeFlag <= pcf;
      extIrqPin <= ext;
      wait_osc(8);
      chk(deviceReset, 1'b0, "wake without reset");
      @(posedge mclk);
      periphFlag <= 8'h00;
      portChangeFlag <= 1'b0;
      step(sn);
      chk(sn, 1'b0, "in-line resume");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int n;
      logic sn;
      logic [31:0] cw;
      logic [7:0] drv, oe;
      void'($urandom(32'hed21));
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      rchk(`SWC_CTRL_OFS, 32'h0000_0000, "ctrl reset");
      rchk(`SWC_EVMK_OFS, 32'h0000_0000, "mask reset");
      rchk(`SWC_STAT_OFS, stat(1'b1, 1'b1, 1'b0), "status reset");
      rd(8'h10);
      chk(lastResp, `SWC_RESP_SLVERR, "unmapped read");
      wr(8'h10, 32'hFFFF_FFFF);
      chk(lastResp, `SWC_RESP_SLVERR, "unmapped write");
      $display("Test 1 reset values done");
      wr(`SWC_CTRL_OFS, WDT | RC);
      drv = 8'($urandom);
      oe = 8'($urandom);
      portDrive <= drv;
      portDriveOe <= oe;
      do_sleep();
      chk(prefetchStb, 1'b1, "prefetch strobe");
      chk(prefetchAddr, pcVal + 13'h0001, "prefetch address");
      chk(wdtClear, 1'b1, "watchdog clear");
      chk(oscEnable, 1'b0, "oscillator off");
      rchk(`SWC_STAT_OFS, stat(1'b0, 1'b1, 1'b1), "sleep flags");
      @(posedge mclk);
      portDrive <= ~drv;
      portDriveOe <= ~oe;
      wdtRun <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk({portHeldOe, portHeld}, {oe, drv}, "port hold");
      chk(irq, 1'b0, "masked event");
      wait_osc(300);
      chk(coreStall, 1'b0, "rc resume");
      chk(deviceReset, 1'b0, "watchdog wake");
      rchk(`SWC_STAT_OFS, stat(1'b0, 1'b0, 1'b0), "timeout flag");
      rchk(`SWC_EVST_OFS, 32'h0000_0005, "events");
      wr(`SWC_EVMK_OFS, 32'h0000_0001);
      @(posedge mclk);
      #1;
      chk(irq, 1'b1, "irq raised");
      wr(`SWC_EVST_OFS, 32'h0000_0005);
      @(posedge mclk);
      #1;
      chk(irq, 1'b0, "irq cleared");
      step(sn);
      n = 0;
      while (deviceReset !== 1'b1)
      begin
         @(posedge mclk);
         #1;
         if (++n > 300)
            fail_to("run reset");
      end
      @(posedge mclk);
      wdtRun <= 1'b0;
      $display("Test 2 sleep and watchdog done");
      wr(`SWC_CTRL_OFS, RC | pen(0));
      periphFlag <= 8'h01;
      do_sleep();
      chk(wdtClear, 1'b0, "nop watchdog");
      chk(coreStall, 1'b0, "nop stall");
      rchk(`SWC_STAT_OFS, stat(1'b0, 1'b0, 1'b0), "nop flags");
      @(posedge mclk);
      periphFlag <= 8'h00;
      sleep_wake(RC | pen(0), 8'h01, 1'b0, 1'b0);
      // The pin fell during that sleep with falling edges selected, so the flag stands.
      rchk(`SWC_STAT_OFS, stat(1'b0, 1'b1, 1'b0) | 32'h0000_0008, "late irq");
      for (int i = 1; i < 8; i++)
      begin
         cw = RC | pen(i);
         if (i == 1 || i == 3)
            cw = cw | T1A;
         if (i == 6)
            cw = cw | ADRC;
         sleep_wake(cw, 8'h01 << i, 1'b0, 1'b0);
      end
      sleep_wake(RC | PRT, 8'h00, 1'b1, 1'b0);
      sleep_wake(RC | EXT | EDG, 8'h00, 1'b0, 1'b1);
      sleep_wake(RC | EXT, 8'h00, 1'b0, 1'b0);
      $display("Test 3 wake sources done");
      wr(`SWC_CTRL_OFS, GLOBAL_IRQ_ENABLE | pen(0));
      do_sleep();
      @(posedge mclk);
      periphFlag <= 8'h01;
      wait_osc(8);
      n = 0;
      while (coreStall === 1'b1 && n < 2000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(n, `SWC_OST_CYCLES, "start-up delay");
      step(sn);
      chk(sn, 1'b1, "vector after wake");
      chk(vectorAddr, 13'h0004, "vector address");
      rchk(`SWC_CTRL_OFS, pen(0), "enable cleared");
      @(posedge mclk);
      periphFlag <= 8'h00;
      retfie <= 1'b1;
      @(posedge mclk);
      retfie <= 1'b0;
      rchk(`SWC_CTRL_OFS, GLOBAL_IRQ_ENABLE | pen(0), "enable restored");
      $display("Test 4 crystal wake done");
      wr(`SWC_CTRL_OFS, RC | pen(1));
      wr(`SWC_STAT_OFS, 32'h0000_0008);
      do_sleep();
      @(posedge mclk);
      periphFlag <= 8'h02;
      repeat (20) @(posedge mclk);
      #1;
      chk(oscEnable, 1'b0, "sync timer");
      @(posedge mclk);
      masterClearPinN <= 1'b0;
      @(posedge mclk);
      #1;
      chk(deviceReset, 1'b1, "master clear");
      @(posedge mclk);
      masterClearPinN <= 1'b1;
      periphFlag <= 8'h00;
      wait_osc(8);
      chk(coreStall, 1'b0, "clear leaves sleep");
      $display("Test 5 master clear done");
      end_sim();
   end
endmodule
